// >>> design/afz_pkg.sv
package afz_pkg;
    // Register byte offsets
    localparam logic [11:0] OFS_CFG = 12'h000;
    localparam logic [11:0] OFS_LIVE = 12'h004;
    localparam logic [11:0] OFS_EVSTAT = 12'h008;
    localparam logic [11:0] OFS_EVMASK = 12'h00C;
    localparam logic [11:0] OFS_TIME = 12'h010;
    localparam logic [11:0] OFS_CNTCLR = 12'h014;
    localparam logic [11:0] OFS_SENSSTAT = 12'h018;
    localparam logic [11:0] OFS_ZCNT = 12'h020;
    localparam logic [11:0] OFS_GMASK = 12'h040;
    localparam logic [11:0] OFS_GCTRL = 12'h060;

    // Field positions
    localparam int CFG_IOUNITS_POS = 8;
    localparam int SENSSTAT_GROUP_POS = 4;
    localparam int CNTCLR_BLK_POS = 4;
    localparam int GMASK_PRESS_POS = 4;
    localparam int GCTRL_PHASE_POS = 1;
    localparam int GCTRL_RES_POS = 2;

    // Values after reset
    localparam logic [11:0] CFG_RST = 12'h000;
    localparam logic [25:0] EVMASK_RST = 26'h0000000;
    localparam logic [31:0] GMASK_RST = 32'h00000000;
    localparam logic [11:0] GCTRL_RST = 12'h000;

    // Time-stamp tick: 1 ms at a 4 ns clock
    localparam int MS_TIME_NS = 1000000;
    localparam int CLK_PERIOD_NS = 4;
    localparam int MS_CYCLES_DEF = MS_TIME_NS / CLK_PERIOD_NS;

    typedef struct packed {
        logic [3:0] light;
        logic [3:0] press;
        logic [11:0] present;
        logic arcBin;
        logic phaseOver;
        logic resOver;
        logic phaseBlock;
        logic resBlock;
        logic [3:0] zoneBlock;
        logic [3:0] ioUnits;
        logic [2:0] groupSel;
    } afz_pin_t;

    typedef struct packed {
        logic [3:0] light;
        logic [3:0] press;
        logic arcBin;
        logic phaseStart;
        logic resStart;
        logic phaseBlocked;
        logic resBlocked;
        logic [3:0] zoneTrip;
        logic [3:0] zoneBlocked;
        logic [3:0] sensorFault;
        logic ioFault;
    } afz_out_t;

    typedef struct packed {
        logic valid;
        logic [4:0] index;
        logic on;
        logic [31:0] stamp;
    } afz_event_t;
endpackage

// >>> design/afz_trip_logic.sv
// Function
// (R1) Four sensor channels, each taking up to three light or pressure sensors.
// (R2) With current enabled, a zone trips only on light and overcurrent together.
// (R3) Eight setting groups, active one chosen by one common select input.
// (R4) Per-channel light output follows that channel's light detection.
// (R5) Per-channel pressure output follows that channel's pressure detection.
// (R6) Arc binary input status follows the energized arc binary input.
// (R7) Phase and residual start outputs when each current exceeds its limit.
// (R8) Phase or residual blocked output when that current is blocked by input.
// (R9) Zone trip when light, or light plus enabled current, conditions hold.
// (R10) Blocking input turns a zone trip into the zone blocked output.
// (R11) Sensor fault per channel when detected and configured counts differ.
// (R12) I/O unit fault when found and configured external unit counts differ.
// (R13) Each change of the 26 outputs emits a time-stamped ON or OFF event; a bit re-toggled while pending gives one event, at its latest level.
// (R14) Event time stamps count in milliseconds.
// (R15) Per-zone cumulative trip and blocked counters, clearable on request.
// (R16) Configured sensor count 0 to 3; status 0 OK, 1 configuration fault.
// (R17) Enabled current channel adds an over-limit current need to light.
// (R18) Per-zone enable and light and pressure channel masks, ORed detections.
//
// The register addresses and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
module afz_trip_logic
    import afz_pkg::*;
#(
    parameter int MS_CYCLES = MS_CYCLES_DEF,
    parameter int CNT_W = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Sensor and field pins
    input wire afz_pin_t pinIn,
    // Protection outputs
    output afz_out_t sigOut,
    // Event stream to the common event buffer
    output afz_event_t eventOut,
    // Interrupt
    output logic irq
);

    // Divider needs two cycles; count readback packs 16 bits
    if (MS_CYCLES < 2 || CNT_W < 1 || CNT_W > 16) begin : g_paramCheck
        $error("afz_trip_logic: unsupported parameter values");
    end

    localparam int NOUT = $bits(afz_out_t);

    // Pin synchronisers
    logic [$bits(afz_pin_t)-1:0] syncA_reg;
    logic [$bits(afz_pin_t)-1:0] syncB_reg;
    afz_pin_t pins;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            syncA_reg <= '0;
            syncB_reg <= '0;
        end else begin
            syncA_reg <= pinIn;
            syncB_reg <= syncA_reg;
        end
    end
    assign pins = afz_pin_t'(syncB_reg);

    // Software state
    logic [11:0] cfg_reg;
    logic [25:0] evMask_reg;
    logic [25:0] evStat_reg;
    logic [31:0] gMask_reg [8];
    logic [11:0] gCtrl_reg [8];
    logic [CNT_W-1:0] tripCnt_reg [4];
    logic [CNT_W-1:0] blkCnt_reg [4];
    logic [2:0] actGroup_reg;
    logic [31:0] msTime_reg;
    logic [31:0] msDiv_reg;

    // APB handshake
    logic pready_reg;
    logic [31:0] prdata_reg;
    logic pslverr_reg;
    logic xferDone;
    logic wrDone;
    logic rdDone;
    logic [31:0] rdData;
    logic rdHit;
    logic [2:0] idx;

    assign xferDone = psel && penable && pready_reg;
    assign wrDone = xferDone && pwrite && rdHit;
    assign rdDone = xferDone && !pwrite;
    assign idx = paddr[4:2];

    // Active setting group
    logic [31:0] gm;
    logic [11:0] gc;

    // (R3) common group select
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            actGroup_reg <= 3'h0;
        end else begin
            actGroup_reg <= pins.groupSel;
        end
    end
    assign gm = gMask_reg[actGroup_reg];
    assign gc = gCtrl_reg[actGroup_reg];

    // Output formation
    afz_out_t outNext;
    afz_out_t out_reg;
    logic [3:0] zoneCond;

    genvar c;
    generate
        for (c = 0; c < 4; c++) begin : g_ch
            logic [1:0] found;
            // (R1) count present sensors
            assign found = 2'({1'b0, pins.present[3*c]}) + 2'({1'b0, pins.present[3*c+1]})
                + 2'({1'b0, pins.present[3*c+2]});
            // (R4) light detected
            assign outNext.light[c] = pins.light[c];
            // (R5) pressure detected
            assign outNext.press[c] = pins.press[c];
            // (R11) (R16) count mismatch
            assign outNext.sensorFault[c] = found != cfg_reg[2*c+:2];
        end
        for (c = 0; c < 4; c++) begin : g_zone
            logic lightCond;
            logic curOk;
            // (R18) masked channel OR
            assign lightCond = |(gm[8*c+:4] & pins.light) | |(gm[8*c+GMASK_PRESS_POS+:4] & pins.press);
            // (R2) (R17) current qualification
            assign curOk = (!gc[3*c+GCTRL_PHASE_POS] || pins.phaseOver)
                && (!gc[3*c+GCTRL_RES_POS] || pins.resOver);
            // (R9) zone conditions
            assign zoneCond[c] = gc[3*c] && lightCond && curOk;
            assign outNext.zoneTrip[c] = zoneCond[c] && !pins.zoneBlock[c];
            // (R10) blocked instead of trip
            assign outNext.zoneBlocked[c] = zoneCond[c] && pins.zoneBlock[c];
        end
    endgenerate

    // (R6) arc binary input
    assign outNext.arcBin = pins.arcBin;
    // (R7) current starts
    assign outNext.phaseStart = pins.phaseOver && !pins.phaseBlock;
    assign outNext.resStart = pins.resOver && !pins.resBlock;
    // (R8) current blocked
    assign outNext.phaseBlocked = pins.phaseOver && pins.phaseBlock;
    assign outNext.resBlocked = pins.resOver && pins.resBlock;
    // (R12) unit count mismatch
    assign outNext.ioFault = pins.ioUnits != cfg_reg[CFG_IOUNITS_POS+:4];

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            out_reg <= '0;
        end else begin
            out_reg <= outNext;
        end
    end
    assign sigOut = out_reg;

    // Change detection
    logic [25:0] change;
    assign change = outNext ^ out_reg;

    // (R14) millisecond time base
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            msDiv_reg <= 32'h00000000;
            msTime_reg <= 32'h00000000;
        end else if (msDiv_reg == 32'(MS_CYCLES - 1)) begin
            msDiv_reg <= 32'h00000000;
            msTime_reg <= msTime_reg + 32'h00000001;
        end else begin
            msDiv_reg <= msDiv_reg + 32'h00000001;
        end
    end

    // Event queue: one pending bit per output, lowest index first
    logic [25:0] pend_reg;
    logic [25:0] pendOn_reg;
    logic [25:0] grant;
    logic [4:0] grantIdx;
    afz_event_t event_reg;

    assign grant = pend_reg & (~pend_reg + 26'h0000001);

    always_comb begin
        grantIdx = 5'h00;
        for (int i = NOUT - 1; i >= 0; i--) begin
            if (pend_reg[i]) begin
                grantIdx = 5'(i);
            end
        end
    end

    // Re-toggled bit keeps only its latest level
    // (R13) pending event capture
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pend_reg <= '0;
            pendOn_reg <= '0;
        end else begin
            pend_reg <= (pend_reg & ~grant) | change;
            pendOn_reg <= (pendOn_reg & ~change) | (change & outNext);
        end
    end

    // (R13) (R14) event emission
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            event_reg <= '0;
        end else begin
            event_reg.valid <= |pend_reg;
            event_reg.index <= grantIdx;
            event_reg.on <= pendOn_reg[grantIdx];
            event_reg.stamp <= msTime_reg;
        end
    end
    assign eventOut = event_reg;

    // (R15) zone counters
    genvar z;
    generate
        for (z = 0; z < 4; z++) begin : g_cnt
            logic tripEdge;
            logic blkEdge;
            logic clrTrip;
            logic clrBlk;
            assign tripEdge = outNext.zoneTrip[z] && !out_reg.zoneTrip[z];
            assign blkEdge = outNext.zoneBlocked[z] && !out_reg.zoneBlocked[z];
            assign clrTrip = wrDone && paddr == OFS_CNTCLR && pwdata[z];
            assign clrBlk = wrDone && paddr == OFS_CNTCLR && pwdata[CNTCLR_BLK_POS+z];
            // Clear with a same-cycle edge leaves one
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    tripCnt_reg[z] <= '0;
                end else if (clrTrip) begin
                    tripCnt_reg[z] <= tripEdge ? CNT_W'(1) : '0;
                end else if (tripEdge && tripCnt_reg[z] != '1) begin
                    tripCnt_reg[z] <= tripCnt_reg[z] + CNT_W'(1);
                end
            end
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    blkCnt_reg[z] <= '0;
                end else if (clrBlk) begin
                    blkCnt_reg[z] <= blkEdge ? CNT_W'(1) : '0;
                end else if (blkEdge && blkCnt_reg[z] != '1) begin
                    blkCnt_reg[z] <= blkCnt_reg[z] + CNT_W'(1);
                end
            end
        end
    endgenerate

    // Interrupt status: set wins over read clear
    logic irq_reg;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            evStat_reg <= '0;
        end else if (rdDone && paddr == OFS_EVSTAT) begin
            // Clear only what the read reported
            evStat_reg <= (evStat_reg & ~prdata_reg[25:0]) | change;
        end else begin
            evStat_reg <= evStat_reg | change;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= |(evStat_reg & evMask_reg);
        end
    end
    assign irq = irq_reg;

    // Register writes
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cfg_reg <= CFG_RST;
            evMask_reg <= EVMASK_RST;
        end else if (wrDone) begin
            if (paddr == OFS_CFG) begin
                cfg_reg <= pwdata[11:0];
            end
            if (paddr == OFS_EVMASK) begin
                evMask_reg <= pwdata[25:0];
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_grp
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    gMask_reg[g] <= GMASK_RST;
                    gCtrl_reg[g] <= GCTRL_RST;
                end else if (wrDone && idx == 3'(g)) begin
                    if (paddr[11:5] == OFS_GMASK[11:5]) begin
                        gMask_reg[g] <= pwdata;
                    end
                    if (paddr[11:5] == OFS_GCTRL[11:5]) begin
                        gCtrl_reg[g] <= pwdata[11:0];
                    end
                end
            end
        end
    endgenerate

    // Read decode
    always_comb begin
        rdData = 32'h00000000;
        rdHit = 1'b1;
        if (paddr[1:0] != 2'h0) begin
            rdHit = 1'b0;
        end else if (paddr == OFS_CFG) begin
            rdData = {20'h00000, cfg_reg};
        end else if (paddr == OFS_LIVE) begin
            rdData = {6'h00, out_reg};
        end else if (paddr == OFS_EVSTAT) begin
            rdData = {6'h00, evStat_reg};
        end else if (paddr == OFS_EVMASK) begin
            rdData = {6'h00, evMask_reg};
        end else if (paddr == OFS_TIME) begin
            rdData = msTime_reg;
        end else if (paddr == OFS_CNTCLR) begin
            rdData = 32'h00000000;
        end else if (paddr == OFS_SENSSTAT) begin
            rdData = {25'h0000000, actGroup_reg, out_reg.sensorFault};
        end else if (paddr[11:4] == OFS_ZCNT[11:4]) begin
            rdData = {16'(blkCnt_reg[idx[1:0]]), 16'(tripCnt_reg[idx[1:0]])};
        end else if (paddr[11:5] == OFS_GMASK[11:5]) begin
            rdData = gMask_reg[idx];
        end else if (paddr[11:5] == OFS_GCTRL[11:5]) begin
            rdData = {20'h00000, gCtrl_reg[idx]};
        end else begin
            rdHit = 1'b0;
        end
    end

    // One wait state: data registered, then pready
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pready_reg <= 1'b0;
            prdata_reg <= 32'h00000000;
            pslverr_reg <= 1'b0;
        end else if (psel && penable && !pready_reg) begin
            pready_reg <= 1'b1;
            prdata_reg <= pwrite ? 32'h00000000 : rdData;
            pslverr_reg <= !rdHit;
        end else begin
            pready_reg <= 1'b0;
            prdata_reg <= 32'h00000000;
            pslverr_reg <= 1'b0;
        end
    end
    assign pready = pready_reg;
    assign prdata = prdata_reg;
    assign pslverr = pslverr_reg;

endmodule // afz_trip_logic

// >>> tb/afz_trip_checker.sv
`timescale 1ns/1ps
module afz_trip_checker
    import afz_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // APB answer
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    // Pins and outputs
    input wire afz_pin_t pinIn,
    input wire afz_out_t sigOut,
    input wire afz_event_t eventOut
);
    // Cycles since reset release, saturating
    logic [2:0] upCnt;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            upCnt <= 3'h0;
        end else if (upCnt != 3'h7) begin
            upCnt <= upCnt + 3'h1;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    light_follow_a: assert property (upCnt > 3'h3 |-> sigOut.light == $past(pinIn.light, 3))
        else $error("light output does not follow light input");
    press_follow_a: assert property (upCnt > 3'h3 |-> sigOut.press == $past(pinIn.press, 3))
        else $error("pressure output does not follow pressure input");
    arc_input_a: assert property (upCnt > 3'h3 |-> sigOut.arcBin == $past(pinIn.arcBin, 3))
        else $error("arc input status wrong");
    phase_start_a: assert property (upCnt > 3'h3 |-> sigOut.phaseStart == $past(pinIn.phaseOver & !pinIn.phaseBlock, 3))
        else $error("phase start wrong");
    res_start_a: assert property (upCnt > 3'h3 |-> sigOut.resStart == $past(pinIn.resOver & !pinIn.resBlock, 3))
        else $error("residual start wrong");
    cur_blocked_a: assert property (upCnt > 3'h3 |-> {sigOut.phaseBlocked, sigOut.resBlocked} ==
        $past({pinIn.phaseOver & pinIn.phaseBlock, pinIn.resOver & pinIn.resBlock}, 3))
        else $error("current blocked output wrong");
    zone_block_a: assert property (upCnt > 3'h3 |-> ((sigOut.zoneTrip & $past(pinIn.zoneBlock, 3)) == 4'h0)
        && ((sigOut.zoneBlocked & ~$past(pinIn.zoneBlock, 3)) == 4'h0))
        else $error("zone trip not suppressed by block");
    trip_event_a: assert property ($rose(sigOut.zoneTrip[0]) |->
        ##[1:26] (eventOut.valid && eventOut.index == 5'h09 && eventOut.on))
        else $error("zone trip event missing");
    ready_wait_a: assert property (psel && penable && !$past(penable) |-> !pready ##1 pready ##1 !pready)
        else $error("ready timing wrong");
    error_ready_a: assert property (pslverr |-> pready)
        else $error("error without ready");
endmodule // afz_trip_checker

bind afz_trip_logic afz_trip_checker i_afz_trip_checker (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pready(pready), .pslverr(pslverr), .pinIn(pinIn), .sigOut(sigOut), .eventOut(eventOut));

// >>> tb/afz_field_model.sv
`timescale 1ns/1ps
module afz_field_model
    import afz_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Wanted field state
    input wire afz_pin_t want,
    // Sensor and field pins
    output afz_pin_t pinOut = '0
);
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            pinOut <= '0;
        end else begin
            pinOut <= want;
        end
    end
endmodule // afz_field_model

// >>> tb/testbench.sv
`timescale 1ns/1ps
module testbench;
    import afz_pkg::*;
    localparam int MS_CYC = 10;
    localparam logic [11:0] CFG_VAL = 12'h239;
    localparam logic [31:0] GM0 = 32'h80042201;
    localparam logic [11:0] GC0 = 12'h359;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    afz_pin_t want = '0;
    afz_pin_t pinIn;
    afz_out_t sigOut;
    afz_out_t expOut;
    afz_event_t eventOut;
    afz_event_t lastEv = '0;
    logic [31:0] rdVal;
    logic [31:0] tRef;
    logic errBit;
    int n_fail = 0;
    int n_compared = 0;
    afz_pin_t rows [7] = '{36'h001D90010, 36'h101D90010, 36'h281D90010, 36'h201D94110,
        36'h401D9A810, 36'h000005000, 36'hFFFFFFFF8};
    int seq [6] = '{0, 1, 0, 1, 3, 0};

    afz_trip_logic #(.MS_CYCLES(MS_CYC), .CNT_W(16)) i_afz_trip_logic (.clk(clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pinIn(pinIn), .sigOut(sigOut), .eventOut(eventOut), .irq(irq));
    afz_field_model i_afz_field_model (.clk(clk), .rst(rst), .want(want), .pinOut(pinIn));

    always #2 clk = ~clk;
    always @(posedge clk) begin
        if (eventOut.valid === 1'b1 && eventOut.index === 5'h09) begin
            lastEv <= eventOut;
        end
    end

    function automatic afz_out_t refOut(afz_pin_t p, logic [31:0] m, logic [11:0] c);
        afz_out_t o;
        logic cond;
        o = '0;
        o.light = p.light;
        o.press = p.press;
        o.arcBin = p.arcBin;
        o.phaseStart = p.phaseOver & ~p.phaseBlock;
        o.phaseBlocked = p.phaseOver & p.phaseBlock;
        o.resStart = p.resOver & ~p.resBlock;
        o.resBlocked = p.resOver & p.resBlock;
        for (int z = 0; z < 4; z++) begin
            cond = c[3*z] & ((|(m[8*z+:4] & p.light)) | (|(m[8*z+4+:4] & p.press)))
                & (~c[3*z+1] | p.phaseOver) & (~c[3*z+2] | p.resOver);
            o.zoneTrip[z] = cond & ~p.zoneBlock[z];
            o.zoneBlocked[z] = cond & p.zoneBlock[z];
            o.sensorFault[z] = (2'(p.present[3*z]) + 2'(p.present[3*z+1]) + 2'(p.present[3*z+2])) != CFG_VAL[2*z+:2];
        end
        o.ioFault = p.ioUnits != CFG_VAL[11:8];
        return o;
    endfunction

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            $display("ERROR %s expected %h seen %h", name, exp, got);
            n_fail++;
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rdVal = prdata;
        errBit = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        chk("pready", 32'h1, {31'h0, pready});
    endtask

    task automatic setPins(input afz_pin_t p);
        @(posedge clk);
        want <= p;
        repeat (8) @(posedge clk);
    endtask

    task automatic end_sim;
        $display("Compared %0d, mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        #200000;
        n_fail++;
        end_sim();
    end

    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        apb(1'b1, 12'h002, 32'hFFFFFFFF);
        chk("unaligned err", 32'h1, {31'h0, errBit});
        apb(1'b0, 12'h01C, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, errBit});
        chk("unmapped data", 32'h0, rdVal);
        apb(1'b0, OFS_CFG, 32'h0);
        chk("CFG reset", {20'h00000, CFG_RST}, rdVal);
        apb(1'b0, OFS_EVMASK, 32'h0);
        chk("EVMASK reset", {6'h00, EVMASK_RST}, rdVal);
        apb(1'b0, OFS_GCTRL, 32'h0);
        chk("GCTRL reset", {20'h00000, GCTRL_RST}, rdVal);
        apb(1'b1, OFS_CFG, {20'h00000, CFG_VAL});
        apb(1'b1, OFS_GMASK, GM0);
        apb(1'b1, OFS_GCTRL, {20'h00000, GC0});
        for (int i = 0; i < 7; i++) begin
            setPins(rows[i]);
            expOut = refOut(rows[i], GM0, GC0);
            chk("sigOut", {6'h00, expOut}, {6'h00, sigOut});
            apb(1'b0, OFS_LIVE, 32'h0);
            chk("LIVE", {6'h00, expOut}, rdVal);
            apb(1'b0, OFS_SENSSTAT, 32'h0);
            chk("SENSSTAT", {28'h0, expOut.sensorFault}, rdVal);
        end
        apb(1'b1, OFS_GMASK + 12'h004, 32'h0000000F);
        apb(1'b1, OFS_GCTRL + 12'h004, 32'h00000001);
        setPins(36'h801D92011);
        chk("group 1", {6'h00, refOut(36'h801D92011, 32'h0000000F, 12'h001)}, {6'h00, sigOut});
        apb(1'b0, OFS_SENSSTAT, 32'h0);
        chk("group field", 32'h00000010, rdVal);
        apb(1'b1, OFS_CNTCLR, 32'h000000FF);
        for (int k = 0; k < 6; k++) begin
            setPins(rows[seq[k]]);
        end
        apb(1'b0, OFS_ZCNT, 32'h0);
        chk("zone 0 count", 32'h00000002, rdVal);
        apb(1'b0, OFS_ZCNT + 12'h004, 32'h0);
        chk("zone 1 count", 32'h00010000, rdVal);
        apb(1'b1, OFS_CNTCLR, 32'h00000020);
        apb(1'b0, OFS_ZCNT + 12'h004, 32'h0);
        chk("zone 1 cleared", 32'h00000000, rdVal);
        apb(1'b0, OFS_ZCNT, 32'h0);
        chk("zone 0 kept", 32'h00000002, rdVal);
        apb(1'b1, OFS_EVMASK, 32'h00000200);
        apb(1'b0, OFS_EVSTAT, 32'h0);
        setPins(rows[1]);
        chk("irq set", 32'h1, {31'h0, irq});
        chk("event on", 32'h1, {31'h0, lastEv.on});
        apb(1'b0, OFS_TIME, 32'h0);
        chk("stamp near time", 32'h1, {31'h0, (rdVal - lastEv.stamp) <= 32'h2});
        apb(1'b0, OFS_EVSTAT, 32'h0);
        chk("EVSTAT", 32'h00400200, rdVal);
        repeat (2) @(posedge clk);
        chk("irq cleared", 32'h0, {31'h0, irq});
        apb(1'b1, OFS_EVMASK, 32'h00000000);
        setPins(rows[0]);
        chk("irq masked", 32'h0, {31'h0, irq});
        apb(1'b0, OFS_EVSTAT, 32'h0);
        chk("EVSTAT off", 32'h00400200, rdVal);
        apb(1'b0, OFS_TIME, 32'h0);
        tRef = rdVal;
        repeat (96) @(posedge clk);
        apb(1'b0, OFS_TIME, 32'h0);
        chk("ms count", 32'd10, rdVal - tRef);
        setPins(rows[6]);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        chk("reset sigOut", 32'h0, {6'h00, sigOut});
        chk("reset irq", 32'h0, {31'h0, irq});
        chk("reset event", 32'h0, {31'h0, eventOut.valid});
        chk("reset pready", 32'h0, {31'h0, pready});
        rst <= 1'b0;
        apb(1'b0, OFS_GMASK, 32'h0);
        chk("GMASK after reset", GMASK_RST, rdVal);
        apb(1'b0, OFS_CFG, 32'h0);
        chk("CFG after reset", {20'h00000, CFG_RST}, rdVal);
        apb(1'b1, OFS_CFG, {20'h00000, CFG_VAL});
        apb(1'b1, OFS_GMASK, GM0);
        apb(1'b1, OFS_GCTRL, {20'h00000, GC0});
        setPins(rows[1]);
        chk("after reset", {6'h00, refOut(rows[1], GM0, GC0)}, {6'h00, sigOut});
        end_sim();
    end
endmodule // testbench
